// *** hw/pcc_config.sv ***
// Packet path and carrier configuration registers with their decoded controls.
// Assumes a serial port front end on mclk_i that presents one-cycle read and write strobes.
`timescale 1ns/1ns
`include "pcc_map.svh"

module pcc_config
    import pcc_pkg::*;
#(
    parameter int SPACING_W = 16,
    parameter int WORD_W = 26
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic whitening_on_o,
    output logic fifo_path_o,
    output logic serial_sync_o,
    output logic random_tx_o,
    output logic transparent_o,
    output logic crc_gen_o,
    output logic crc_check_o,
    output logic fixed_len_o,
    output logic var_len_o,
    output logic infinite_len_o,
    output logic [7:0] packet_size_o,
    input wire logic rx_addr_valid_i,
    input wire logic [7:0] rx_addr_i,
    output logic addr_done_o,
    output logic addr_accept_o,
    input wire logic [15:0] carrier_word_low_i,
    input wire logic [SPACING_W-1:0] slot_index_spacing_i,
    input wire logic rx_mode_i,
    output logic [WORD_W-1:0] synth_word_o,
    output logic [4:0] mixer_if_o,
    input wire logic gp_pin_zero_i,
    input wire logic fifo_tx_bit_i,
    input wire logic tx_bit_en_i,
    output logic tx_bit_o,
    input wire logic rx_demod_bit_i,
    output logic gp_rx_data_o
);

    // ----------------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------------
    logic whitening_on;
    pcc_format_t data_path_format;
    logic crc_on;
    pcc_length_t length_mode;
    logic [7:0] packet_size_reg;
    pcc_check_t node_id_check;
    logic [7:0] node_id;
    logic [7:0] slot_index;
    logic [4:0] intermediate_step;
    logic [7:0] carrier_trim;
    logic [5:0] carrier_high;
    logic pin_meta;
    logic pin_sync;
    logic pn9_bit;

    function automatic logic addr_match(input pcc_check_t mode, input logic [7:0] rx, input logic [7:0] own);
        logic hit;
        hit = (rx == own);
        case (mode)
            PCC_CHK_NONE: addr_match = 1'b1;
            PCC_CHK_NO_BCAST: addr_match = hit;
            PCC_CHK_ZERO_BCAST: addr_match = hit || (rx == `PCC_BROADCAST_ZERO);
            PCC_CHK_BOTH_BCAST: addr_match = hit || (rx == `PCC_BROADCAST_ZERO) || (rx == `PCC_BROADCAST_ONES);
            default: addr_match = 1'b0;
        endcase
    endfunction : addr_match

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            whitening_on <= `PCC_RST_WHITENING;
            data_path_format <= pcc_format_t'(`PCC_RST_FORMAT);
            crc_on <= `PCC_RST_CRC;
            length_mode <= pcc_length_t'(`PCC_RST_LENGTH);
            packet_size_reg <= `PCC_RST_PACKET_SIZE;
            node_id_check <= pcc_check_t'(`PCC_RST_NODE_ID_CHECK);
            node_id <= `PCC_RST_NODE_ID;
            slot_index <= `PCC_RST_SLOT_INDEX;
            intermediate_step <= `PCC_RST_IF_STEP;
            carrier_trim <= `PCC_RST_TRIM;
            carrier_high <= `PCC_RST_CARRIER_HIGH;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `PCC_OFF_PACKET_PATH: begin
                    whitening_on <= reg_wdata_i[`PCC_BIT_WHITENING];
                    data_path_format <= pcc_format_t'(reg_wdata_i[`PCC_POS_FORMAT +: 2]);
                    crc_on <= reg_wdata_i[`PCC_BIT_CRC];
                    length_mode <= pcc_length_t'(reg_wdata_i[`PCC_POS_LENGTH +: 2]);
                end
                `PCC_OFF_PACKET_SIZE: packet_size_reg <= reg_wdata_i;
                `PCC_OFF_NODE_ID_CHECK: node_id_check <= pcc_check_t'(reg_wdata_i[1:0]);
                `PCC_OFF_NODE_ID: node_id <= reg_wdata_i;
                `PCC_OFF_SLOT_INDEX: slot_index <= reg_wdata_i;
                `PCC_OFF_SYNTH_IF: intermediate_step <= reg_wdata_i[4:0];
                `PCC_OFF_SYNTH_OFFSET: carrier_trim <= reg_wdata_i;
                `PCC_OFF_CARRIER_HIGH: carrier_high <= reg_wdata_i[5:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `PCC_OFF_PACKET_PATH: reg_rdata_o <= {1'b0, whitening_on, data_path_format, 1'b0, crc_on,
                        length_mode};
                    `PCC_OFF_PACKET_SIZE: reg_rdata_o <= packet_size_reg;
                    `PCC_OFF_NODE_ID_CHECK: reg_rdata_o <= {6'h00, node_id_check};
                    `PCC_OFF_NODE_ID: reg_rdata_o <= node_id;
                    `PCC_OFF_SLOT_INDEX: reg_rdata_o <= slot_index;
                    `PCC_OFF_SYNTH_IF: reg_rdata_o <= {3'h0, intermediate_step};
                    `PCC_OFF_SYNTH_OFFSET: reg_rdata_o <= carrier_trim;
                    `PCC_OFF_CARRIER_HIGH: reg_rdata_o <= {2'h0, carrier_high};
                    default: reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Decoded packet engine controls
    // ----------------------------------------------------------------
    assign whitening_on_o = whitening_on;
    // Random test mode receives exactly as FIFO mode does.
    assign fifo_path_o = (data_path_format == PCC_FMT_FIFO) || (data_path_format == PCC_FMT_RANDOM_TX);
    assign serial_sync_o = (data_path_format == PCC_FMT_SERIAL_SYNC);
    assign random_tx_o = (data_path_format == PCC_FMT_RANDOM_TX);
    assign transparent_o = (data_path_format == PCC_FMT_TRANSPARENT);
    assign crc_gen_o = crc_on;
    assign crc_check_o = crc_on;
    assign fixed_len_o = (length_mode == PCC_LEN_FIXED);
    assign var_len_o = (length_mode == PCC_LEN_VARIABLE);
    // The reserved length code selects no mode at all.
    assign infinite_len_o = (length_mode == PCC_LEN_INFINITE);
    assign packet_size_o = packet_size_reg;
    assign mixer_if_o = intermediate_step;

    // ----------------------------------------------------------------
    // Receive address filter
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_done_o <= 1'b0;
            addr_accept_o <= 1'b0;
        end else begin
            addr_done_o <= rx_addr_valid_i;
            if (rx_addr_valid_i) begin
                addr_accept_o <= addr_match(node_id_check, rx_addr_i, node_id);
            end
        end
    end

    // ----------------------------------------------------------------
    // Synthesizer word
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] base_term;
    logic [WORD_W-1:0] slot_index_term;
    logic [WORD_W-1:0] trim_term;
    logic [WORD_W-1:0] if_term;

    assign base_term = WORD_W'({2'h0, carrier_high, carrier_word_low_i});
    assign slot_index_term = WORD_W'(slot_index) * WORD_W'(slot_index_spacing_i);
    assign trim_term = WORD_W'($signed({carrier_trim, `PCC_TRIM_SHIFT'(0)}));
    assign if_term = rx_mode_i ? WORD_W'({intermediate_step, `PCC_IF_SHIFT'(0)}) : '0;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            synth_word_o <= '0;
        end else begin
            synth_word_o <= WORD_W'(base_term + slot_index_term + trim_term - if_term);
        end
    end

    // ----------------------------------------------------------------
    // Serial data paths
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= gp_pin_zero_i;
            pin_sync <= pin_meta;
        end
    end

    pcc_pn9 #(
        .WIDTH(9)
    ) u_pn9 (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .step_i(tx_bit_en_i && random_tx_o),
        .bit_o(pn9_bit)
    );

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_bit_o <= 1'b0;
        end else begin
            case (data_path_format)
                PCC_FMT_FIFO: if (tx_bit_en_i) tx_bit_o <= fifo_tx_bit_i;
                PCC_FMT_SERIAL_SYNC: if (tx_bit_en_i) tx_bit_o <= pin_sync;
                PCC_FMT_RANDOM_TX: if (tx_bit_en_i) tx_bit_o <= pn9_bit;
                PCC_FMT_TRANSPARENT: tx_bit_o <= pin_sync;
                default: tx_bit_o <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gp_rx_data_o <= 1'b0;
        end else begin
            gp_rx_data_o <= transparent_o ? rx_demod_bit_i : 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_white_write;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == `PCC_OFF_PACKET_PATH) |=> (whitening_on_o == $past(reg_wdata_i[6]));
    endproperty
    a_white_write: assert property (p_white_write) else $error("whitening flag not taken from write");

    property p_fifo_tx;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (data_path_format == PCC_FMT_FIFO && tx_bit_en_i) ##1 (data_path_format == PCC_FMT_FIFO)
        |-> tx_bit_o == $past(fifo_tx_bit_i);
    endproperty
    a_fifo_tx: assert property (p_fifo_tx) else $error("fifo bit not sent");

    property p_serial_pin;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (serial_sync_o && tx_bit_en_i) ##1 serial_sync_o |-> tx_bit_o == $past(gp_pin_zero_i, 3);
    endproperty
    a_serial_pin: assert property (p_serial_pin) else $error("serial pin bit not sent");

    property p_random_tx;
        @(posedge mclk_i) disable iff (!rst_b_i)
        random_tx_o |-> fifo_path_o && !serial_sync_o && !transparent_o;
    endproperty
    a_random_tx: assert property (p_random_tx) else $error("random mode does not receive via fifo");

    property p_transparent_out;
        @(posedge mclk_i) disable iff (!rst_b_i)
        transparent_o ##1 transparent_o |-> gp_rx_data_o == $past(rx_demod_bit_i);
    endproperty
    a_transparent_out: assert property (p_transparent_out) else $error("transparent rx data wrong");

    property p_crc_pair;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == `PCC_OFF_PACKET_PATH)
        |=> crc_gen_o == $past(reg_wdata_i[2]) && crc_check_o == crc_gen_o;
    endproperty
    a_crc_pair: assert property (p_crc_pair) else $error("crc enables disagree");

    property p_length_onehot;
        @(posedge mclk_i) disable iff (!rst_b_i)
        $countones({fixed_len_o, var_len_o, infinite_len_o}) == (length_mode != PCC_LEN_RESERVED);
    endproperty
    a_length_onehot: assert property (p_length_onehot) else $error("length mode decode wrong");

    property p_addr_filter;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (rx_addr_valid_i && node_id_check == PCC_CHK_NO_BCAST)
        |=> addr_done_o && addr_accept_o == ($past(rx_addr_i) == $past(node_id));
    endproperty
    a_addr_filter: assert property (p_addr_filter) else $error("address filter result wrong");

    property p_bcast_ones;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (rx_addr_valid_i && rx_addr_i == 8'hff
            && node_id_check != PCC_CHK_ZERO_BCAST && node_id_check != PCC_CHK_NO_BCAST)
        |=> addr_accept_o;
    endproperty
    a_bcast_ones: assert property (p_bcast_ones) else $error("all-ones broadcast rejected");

    property p_carrier_read;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_rd_i && reg_addr_i == `PCC_OFF_CARRIER_HIGH) |=> reg_rvalid_o && reg_rdata_o[7:6] == 2'h0;
    endproperty
    a_carrier_read: assert property (p_carrier_read) else $error("carrier high bits not zero");

    property p_size_write;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == `PCC_OFF_PACKET_SIZE) |=> packet_size_o == $past(reg_wdata_i);
    endproperty
    a_size_write: assert property (p_size_write) else $error("packet size not taken from write");

    property p_path_reserved;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_rd_i && reg_addr_i == `PCC_OFF_PACKET_PATH) |=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[3] == 1'b0;
    endproperty
    a_path_reserved: assert property (p_path_reserved) else $error("reserved control bits not zero");

    property p_synth_tx;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (!rx_mode_i && carrier_trim == 8'h00 && slot_index == 8'h00) ##1 $stable(carrier_high)
        |-> synth_word_o == WORD_W'({$past(carrier_high), $past(carrier_word_low_i)});
    endproperty
    a_synth_tx: assert property (p_synth_tx) else $error("synth word not base");

    c_random: cover property (@(posedge mclk_i) disable iff (!rst_b_i) random_tx_o && tx_bit_en_i);
    c_transparent: cover property (@(posedge mclk_i) disable iff (!rst_b_i) transparent_o && rx_demod_bit_i);
    c_accept: cover property (@(posedge mclk_i) disable iff (!rst_b_i) addr_done_o && addr_accept_o);
    c_rx_if: cover property (@(posedge mclk_i) disable iff (!rst_b_i) rx_mode_i && intermediate_step != 5'h00);

endmodule : pcc_config

// *** hw/pcc_pn9.sv ***
// Nine-stage pseudo-random bit generator, polynomial x^9 + x^5 + 1.
// Assumes a single clock; step_i advances the sequence by one bit.
`timescale 1ns/1ns
`include "pcc_map.svh"

module pcc_pn9 #(
    parameter int WIDTH = 9
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic step_i,
    output logic bit_o
);

    logic [WIDTH-1:0] lfsr;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lfsr <= WIDTH'(`PCC_PN9_SEED);
        end else if (step_i) begin
            lfsr <= {lfsr[0] ^ lfsr[5], lfsr[WIDTH-1:1]};
        end
    end

    assign bit_o = lfsr[0];

endmodule : pcc_pn9

// *** shared/pcc_map.svh ***
// Register map, field positions, reset values and scaling for the packet and carrier configuration bank.
// Assumes an 8-bit register address and 8-bit data supplied by the serial port front end.
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH

`define PCC_OFF_PACKET_SIZE 8'h06
`define PCC_OFF_NODE_ID_CHECK 8'h07
`define PCC_OFF_PACKET_PATH 8'h08
`define PCC_OFF_NODE_ID 8'h09
`define PCC_OFF_SLOT_INDEX 8'h0a
`define PCC_OFF_SYNTH_IF 8'h0b
`define PCC_OFF_SYNTH_OFFSET 8'h0c
`define PCC_OFF_CARRIER_HIGH 8'h0d

`define PCC_BIT_WHITENING 6
`define PCC_POS_FORMAT 4
`define PCC_BIT_CRC 2
`define PCC_POS_LENGTH 0

`define PCC_RST_WHITENING 1'h1
`define PCC_RST_FORMAT 2'h0
`define PCC_RST_CRC 1'h1
`define PCC_RST_LENGTH 2'h1
`define PCC_RST_PACKET_SIZE 8'hff
`define PCC_RST_NODE_ID_CHECK 2'h0
`define PCC_RST_NODE_ID 8'h00
`define PCC_RST_SLOT_INDEX 8'h00
`define PCC_RST_IF_STEP 5'h0f
`define PCC_RST_TRIM 8'h00
`define PCC_RST_CARRIER_HIGH 6'h1e

`define PCC_BROADCAST_ZERO 8'h00
`define PCC_BROADCAST_ONES 8'hff

// Shift from each step size to the carrier word step of fxosc/2^16.
`define PCC_TRIM_SHIFT 2
`define PCC_IF_SHIFT 6

`define PCC_PN9_SEED 9'h1ff

`endif

// *** shared/pcc_pkg.sv ***
// Types shared by the packet and carrier configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
package pcc_pkg;

    typedef enum logic [1:0] {
        PCC_FMT_FIFO,
        PCC_FMT_SERIAL_SYNC,
        PCC_FMT_RANDOM_TX,
        PCC_FMT_TRANSPARENT
    } pcc_format_t;

    typedef enum logic [1:0] {
        PCC_LEN_FIXED,
        PCC_LEN_VARIABLE,
        PCC_LEN_INFINITE,
        PCC_LEN_RESERVED
    } pcc_length_t;

    typedef enum logic [1:0] {
        PCC_CHK_NONE,
        PCC_CHK_NO_BCAST,
        PCC_CHK_ZERO_BCAST,
        PCC_CHK_BOTH_BCAST
    } pcc_check_t;

endpackage : pcc_pkg

// *** testbench/pcc_config_test.sv ***
// Self-checking bench for the packet and carrier configuration bank.
// Assumes the host model in pcc_host_model.sv drives the register port.
`timescale 1ns/1ns
`include "pcc_map.svh"

module pcc_config_test;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, packet_size_o, rx_addr_i = 8'h00;
    logic reg_wr, reg_rd, reg_rvalid, addr_done_o, addr_accept_o, tx_bit_o, gp_rx_data_o;
    logic whitening_on_o, fifo_path_o, serial_sync_o, random_tx_o, transparent_o;
    logic crc_gen_o, crc_check_o, fixed_len_o, var_len_o, infinite_len_o;
    logic rx_addr_valid_i = 1'b0, rx_mode_i = 1'b0, gp_pin_zero_i = 1'b0, fifo_tx_bit_i = 1'b0;
    logic tx_bit_en_i = 1'b0, rx_demod_bit_i = 1'b0;
    logic [15:0] carrier_word_low_i = 16'h0000, slot_index_spacing_i = 16'h0000;
    logic [25:0] synth_word_o;
    logic [4:0] mixer_if_o;
    int n_errors = 0, cmp_count = 0, ones;
    integer seed = 32'h7328;
    logic [7:0] d, hi, slot, ifs, trim, node;
    logic b;
    logic [7:0] offs [8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
    logic [7:0] rvals [8] = '{8'hff, 8'h00, 8'h45, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h1e};
    wire [9:0] ctl = {whitening_on_o, fifo_path_o, serial_sync_o, random_tx_o, transparent_o,
                      crc_gen_o, crc_check_o, fixed_len_o, var_len_o, infinite_len_o};

    always #2 mclk_i = ~mclk_i;

    pcc_host_model host_u (.mclk_i(mclk_i), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid),
        .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd));

    pcc_config #(.SPACING_W(16), .WORD_W(26)) dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .whitening_on_o(whitening_on_o),
        .fifo_path_o(fifo_path_o), .serial_sync_o(serial_sync_o), .random_tx_o(random_tx_o),
        .transparent_o(transparent_o), .crc_gen_o(crc_gen_o), .crc_check_o(crc_check_o),
        .fixed_len_o(fixed_len_o), .var_len_o(var_len_o), .infinite_len_o(infinite_len_o),
        .packet_size_o(packet_size_o), .rx_addr_valid_i(rx_addr_valid_i), .rx_addr_i(rx_addr_i),
        .addr_done_o(addr_done_o), .addr_accept_o(addr_accept_o), .carrier_word_low_i(carrier_word_low_i),
        .slot_index_spacing_i(slot_index_spacing_i), .rx_mode_i(rx_mode_i), .synth_word_o(synth_word_o),
        .mixer_if_o(mixer_if_o), .gp_pin_zero_i(gp_pin_zero_i), .fifo_tx_bit_i(fifo_tx_bit_i),
        .tx_bit_en_i(tx_bit_en_i), .tx_bit_o(tx_bit_o), .rx_demod_bit_i(rx_demod_bit_i),
        .gp_rx_data_o(gp_rx_data_o));

    // ----------------------------------------
    // Comparison and expectation helpers
    // ----------------------------------------
    task automatic note(input bit bad, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (bad) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : note

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        note(got !== exp, 32'(got), 32'(exp));
    endtask : chk_reg

    task automatic chk_ctl(input logic [9:0] got, input logic [9:0] exp);
        note(got !== exp, 32'(got), 32'(exp));
    endtask : chk_ctl

    task automatic chk_word(input logic [25:0] got, input logic [25:0] exp);
        note(got !== exp, 32'(got), 32'(exp));
    endtask : chk_word

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] v;
        host_u.rd(addr, v);
        chk_ctl(10'(host_u.rd_ok), 10'h001);
        chk_reg(v, exp);
    endtask : rd_chk

    function automatic logic [9:0] exp_ctl(input logic [7:0] v);
        logic [1:0] f;
        logic [1:0] l;
        f = v[5:4];
        l = v[1:0];
        return {v[6], f == 2'h0 || f == 2'h2, f == 2'h1, f == 2'h2, f == 2'h3, v[2], v[2],
                l == 2'h0, l == 2'h1, l == 2'h2};
    endfunction : exp_ctl

    function automatic logic [25:0] exp_synth(input logic [7:0] h, input logic [15:0] lo, input logic [7:0] s,
            input logic [15:0] sp, input logic [7:0] t, input logic [7:0] f, input logic rx);
        logic [25:0] w;
        w = {4'h0, h[5:0], lo} + 26'(s) * 26'(sp) + ({{18{t[7]}}, t} << 2);
        if (rx) begin
            w = w - 26'(f[4:0]) * 26'h40;
        end
        return w;
    endfunction : exp_synth

    function automatic logic exp_acc(input logic [1:0] m, input logic [7:0] a, input logic [7:0] n);
        return m == 2'h0 || a == n || (m >= 2'h2 && a == 8'h00) || (m == 2'h3 && a == 8'hff);
    endfunction : exp_acc

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(negedge mclk_i);
        rst_b_i = 1'b1;
        chk_ctl(ctl, exp_ctl(8'h45));
        for (int i = 0; i < 8; i++) begin
            rd_chk(offs[i], rvals[i]);
        end
        host_u.wr(8'h30, 8'h5a);
        rd_chk(8'h30, 8'h00);
        for (int f = 0; f < 4; f++) begin
            for (int l = 0; l < 3; l++) begin
                host_u.gap = $unsigned($random(seed)) % 3;
                d = $random(seed);
                d[5:4] = 2'(f);
                d[1:0] = 2'(l);
                host_u.wr(`PCC_OFF_PACKET_PATH, d);
                chk_ctl(ctl, exp_ctl(d));
                rd_chk(`PCC_OFF_PACKET_PATH, d & 8'h77);
            end
        end
        d = $random(seed);
        host_u.wr(`PCC_OFF_PACKET_SIZE, d);
        chk_reg(packet_size_o, d);
        for (int i = 0; i < 20; i++) begin
            hi = $random(seed);
            slot = $random(seed);
            ifs = $random(seed);
            trim = $random(seed);
            slot_index_spacing_i = $random(seed);
            if (i == 0) begin
                hi = 8'hff;
                slot = 8'hff;
                ifs = 8'hff;
                trim = 8'h80;
                slot_index_spacing_i = 16'hffff;
            end
            host_u.wr(`PCC_OFF_CARRIER_HIGH, hi);
            host_u.wr(`PCC_OFF_SLOT_INDEX, slot);
            host_u.wr(`PCC_OFF_SYNTH_IF, ifs);
            host_u.wr(`PCC_OFF_SYNTH_OFFSET, trim);
            carrier_word_low_i = $random(seed);
            rx_mode_i = (i == 0) ? 1'b1 : 1'($random(seed));
            repeat (2) @(negedge mclk_i);
            chk_word(synth_word_o, exp_synth(hi, carrier_word_low_i, slot, slot_index_spacing_i, trim, ifs,
                rx_mode_i));
            chk_reg({3'h0, mixer_if_o}, ifs & 8'h1f);
            rd_chk(`PCC_OFF_CARRIER_HIGH, hi & 8'h3f);
            rd_chk(`PCC_OFF_SYNTH_IF, ifs & 8'h1f);
        end
        for (int m = 0; m < 4; m++) begin
            d = $random(seed);
            node = $random(seed);
            host_u.wr(`PCC_OFF_NODE_ID_CHECK, {d[7:2], 2'(m)});
            host_u.wr(`PCC_OFF_NODE_ID, node);
            rd_chk(`PCC_OFF_NODE_ID_CHECK, 8'(m));
            for (int k = 0; k < 6; k++) begin
                d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : (k == 2) ? node : 8'($random(seed));
                @(negedge mclk_i);
                chk_ctl(10'(addr_done_o), 10'h000);
                rx_addr_valid_i = 1'b1;
                rx_addr_i = d;
                @(negedge mclk_i);
                rx_addr_valid_i = 1'b0;
                rx_addr_i = ~d;
                chk_ctl({8'h00, addr_done_o, addr_accept_o}, {9'h001, exp_acc(2'(m), d, node)});
            end
        end
        rx_demod_bit_i = 1'b1;
        for (int f = 0; f < 2; f++) begin
            host_u.wr(`PCC_OFF_PACKET_PATH, 8'(f << 4));
            repeat (8) begin
                b = $random(seed);
                fifo_tx_bit_i = f ? ~b : b;
                gp_pin_zero_i = f ? b : ~b;
                repeat (3) @(negedge mclk_i);
                tx_bit_en_i = 1'b1;
                @(negedge mclk_i);
                tx_bit_en_i = 1'b0;
                fifo_tx_bit_i = ~b;
                gp_pin_zero_i = ~b;
                chk_ctl({8'h00, tx_bit_o, gp_rx_data_o}, {8'h00, b, 1'b0});
                @(negedge mclk_i);
                chk_ctl(10'(tx_bit_o), 10'(b));
            end
        end
        host_u.wr(`PCC_OFF_PACKET_PATH, 8'h30);
        repeat (8) begin
            b = $random(seed);
            gp_pin_zero_i = b;
            fifo_tx_bit_i = ~b;
            rx_demod_bit_i = ~b;
            repeat (4) @(negedge mclk_i);
            chk_ctl({8'h00, tx_bit_o, gp_rx_data_o}, {8'h00, b, ~b});
        end
        host_u.wr(`PCC_OFF_PACKET_PATH, 8'h20);
        fifo_tx_bit_i = 1'b0;
        ones = 0;
        // A full nine-stage maximal sequence holds exactly 256 ones in any 511 consecutive bits.
        repeat (511) begin
            @(negedge mclk_i);
            tx_bit_en_i = 1'b1;
            @(negedge mclk_i);
            tx_bit_en_i = 1'b0;
            ones += int'(tx_bit_o);
        end
        chk_word(26'(ones), 26'd256);
        close_out();
    end

    initial begin
        #200000;
        n_errors++;
        $display("Watchdog expired at %0t", $time);
        close_out();
    end
endmodule : pcc_config_test

// *** testbench/pcc_host_model.sv ***
// Host model that reaches the configuration bank over its byte-wide register port.
// Assumes the device takes strobes on the rising edge of mclk_i and answers reads one cycle later.
`timescale 1ns/1ns
`include "pcc_map.svh"

module pcc_host_model (
    input wire logic mclk_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o
);
    int unsigned gap = 0;
    logic rd_ok = 1'b0;

    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end

    // Released strobes drop low and address and data lines show the inverse of their last value, so nothing stale is mistaken for a request.
    task automatic release_bus();
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~reg_addr_o;
        reg_wdata_o = ~reg_wdata_o;
    endtask : release_bus

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        repeat (gap + 1) @(negedge mclk_i);
        if (addr == `PCC_OFF_PACKET_PATH && data[1:0] == 2'h3) begin
            data[0] = 1'b0;
        end
        reg_addr_o = addr;
        reg_wdata_o = data;
        reg_wr_o = 1'b1;
        @(negedge mclk_i);
        release_bus();
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        repeat (gap + 1) @(negedge mclk_i);
        reg_addr_o = addr;
        reg_rd_o = 1'b1;
        @(negedge mclk_i);
        release_bus();
        rd_ok = reg_rvalid_i;
        data = reg_rdata_i;
    endtask : rd
endmodule : pcc_host_model
